// >>> src/sbcm_ctrl.sv
/*
 Power-up, configuration latch and mode control of the basis chip.
 Assumes a 50 MHz clock, synchronous active-low reset tied to supply POR,
 and analog comparators delivered as asynchronous levels.
*/
`timescale 1ns/1ps
`include "sbcm_map.svh"
module sbcm_ctrl
  import sbcm_pkg::*;
#(
  parameter int LONG_WINDOW_CYC = `SBCM_LONG_WINDOW_CYC,
  parameter int RESET_DELAY_CYC = `SBCM_RESET_DELAY_CYC
) (
  input  wire logic         i_clock,
  input  wire logic         i_rst_b,
  input  wire logic         i_main_reg_ok,
  input  wire logic         i_main_reg_ov,
  input  wire logic         i_int_pin,
  input  wire logic         i_fail3_test_pin,
  input  wire logic         i_spi_cmd,
  input  wire logic         i_wd_trigger,
  input  wire logic         i_wake_event,
  input  wire logic         i_count_select,
  input  wire logic         i_overvoltage_reset_enable,
  input  wire logic         i_por_flag_clear,
  input  wire logic         i_mode_write,
  input  wire logic [1:0]   i_mode_field,
  input  wire logic         i_fail_output_test_bit,
  output logic              o_int_pulldown_oe,
  output logic              o_int_pin_low,
  output logic              o_reset_output_pin_b,
  output logic              o_fail_outputs_b,
  output logic              o_overvoltage_flag,
  output logic              o_undervoltage_flag,
  output logic              o_por_flag,
  output logic [1:0]        o_mode_field,
  output sbcm_cfg_s         o_cfg,
  output sbcm_periph_s      o_periph,
  output logic              o_wd_configured,
  output logic              o_wd_fail,
  output sbcm_state_e       o_state
);
  sbcm_state_e  state_q;
  logic [2:0]   int_sync_q;
  logic [2:0]   tst_sync_q;
  logic [2:0]   reg_sync_q;
  logic [2:0]   ov_sync_q;
  logic [31:0]  wd_cnt_q;
  logic [31:0]  rd_cnt_q;
  logic [15:0]  filt_cnt_q;
  logic         filt_val_q;
  logic         stable_q;
  logic         ro_b_q;
  logic         fail_q;
  logic [1:0]   wd_fails_q;
  logic         por_q;
  logic         ov_q;
  logic         ov_seen_q;
  logic         uv_q;
  logic         wd_cfg_q;
  logic         int_q;
  logic         reg_ok_q;
  logic         ov_now_q;
  logic         fail_b_q;
  logic [1:0]   mode_q;
  sbcm_cfg_s    cfg_q;
  sbcm_periph_s periph_q;
  logic         int_lvl;
  logic         reg_ok;
  logic         ov_now;
  logic         wd_expire;
  logic         ov_event;
  logic         ro_rise;
  logic         wd_fail_safe;
  logic         wd_fail_out;
  logic         sampling;

  // Three-stage synchronisers, change accepted when stages two and three agree
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      int_sync_q <= 3'h0;
      tst_sync_q <= 3'h7;
      reg_sync_q <= 3'h0;
      ov_sync_q  <= 3'h0;
    end else begin
      int_sync_q <= {int_sync_q[1:0], i_int_pin};
      tst_sync_q <= {tst_sync_q[1:0], i_fail3_test_pin};
      reg_sync_q <= {reg_sync_q[1:0], i_main_reg_ok};
      ov_sync_q  <= {ov_sync_q[1:0], i_main_reg_ov};
    end
  end
  assign int_lvl = int_sync_q[2];

  // Accepted levels, updated only when stages two and three agree
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      reg_ok_q <= 1'h0;
      ov_now_q <= 1'h0;
    end else begin
      if (reg_sync_q[2] == reg_sync_q[1]) begin
        reg_ok_q <= reg_sync_q[2];
      end
      if (ov_sync_q[2] == ov_sync_q[1]) begin
        ov_now_q <= ov_sync_q[2];
      end
    end
  end
  assign reg_ok  = reg_ok_q;
  assign ov_now  = ov_now_q;

  assign sampling  = !ro_b_q && reg_ok && (por_q || state_q == SBCM_INIT);
  assign ro_rise   = !ro_b_q && reg_ok && rd_cnt_q == 32'h0
                     && state_q != SBCM_FAILSAFE;
  assign wd_expire = !cfg_q.dev_mode && ro_b_q && wd_cnt_q == 32'h0
                     && (state_q == SBCM_INIT || state_q == SBCM_NORMAL);
  assign ov_event  = ov_now && !ov_seen_q && ro_b_q;
  assign wd_fail_out  = cfg_q.count_select || wd_fails_q != 2'h0;
  assign wd_fail_safe = !cfg_q.pullup_config_latch && wd_fail_out;

  // Continuous filter of interrupt level during reset delay, only while the POR flag is set or in Init
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      filt_cnt_q <= 16'h0;
      filt_val_q <= 1'h0;
      stable_q   <= 1'h0;
    end else if (!sampling) begin
      filt_cnt_q <= 16'h0;
      stable_q   <= 1'h0;
    end else if (int_sync_q[2] != int_sync_q[1]) begin
      filt_cnt_q <= 16'h0;
      stable_q   <= 1'h0;
    end else if (filt_cnt_q == 16'(`SBCM_CFG_FILT_CYC - 1)) begin
      filt_val_q <= int_lvl;
      stable_q   <= 1'h1;
    end else begin
      filt_cnt_q <= filt_cnt_q + 16'h1;
    end
  end

  // Configuration latch, pull-up bit only refreshed while POR flag remains, count select every cycle
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      cfg_q <= '{pullup_config_latch: `SBCM_CFG_RST_VAL, count_select: 1'h0, dev_mode: 1'h0};
    end else begin
      cfg_q.count_select <= i_count_select;
      if (ro_rise && por_q) begin
        cfg_q.pullup_config_latch <= stable_q ? filt_val_q : 1'h0;
      end
      if (state_q == SBCM_INIT && sampling && tst_sync_q[2] == tst_sync_q[1]) begin
        cfg_q.dev_mode <= !tst_sync_q[2];
      end
    end
  end

  // Reset output and reset delay
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      ro_b_q   <= 1'h0;
      rd_cnt_q <= 32'(RESET_DELAY_CYC);
    end else if (!reg_ok || wd_expire || (ov_event && i_overvoltage_reset_enable)
                 || state_q == SBCM_FAILSAFE) begin
      ro_b_q   <= 1'h0;
      rd_cnt_q <= 32'(RESET_DELAY_CYC);
    end else if (!ro_b_q) begin
      if (rd_cnt_q != 32'h0) begin
        rd_cnt_q <= rd_cnt_q - 32'h1;
      end else begin
        ro_b_q <= 1'h1;
      end
    end
  end

  // Mode state machine
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      state_q <= SBCM_INIT;
    end else begin
      case (state_q)
        SBCM_INIT: begin
          if (wd_expire) begin
            state_q <= wd_fail_safe ? SBCM_FAILSAFE : SBCM_RESTART;
          end else if (ov_event && i_overvoltage_reset_enable) begin
            state_q <= cfg_q.pullup_config_latch ? SBCM_RESTART : SBCM_FAILSAFE;
          end else if (i_spi_cmd && ro_b_q) begin
            state_q <= SBCM_NORMAL;
          end
        end
        SBCM_NORMAL, SBCM_STOP, SBCM_SLEEP: begin
          if (wd_expire) begin
            state_q <= wd_fail_safe ? SBCM_FAILSAFE : SBCM_RESTART;
          end else if (ov_event && i_overvoltage_reset_enable) begin
            state_q <= cfg_q.pullup_config_latch ? SBCM_RESTART : SBCM_FAILSAFE;
          end else if (!reg_ok) begin
            state_q <= SBCM_RESTART;
          end else if (i_mode_write && state_q == SBCM_NORMAL) begin
            case (i_mode_field)
              2'h1:    state_q <= SBCM_STOP;
              2'h2:    state_q <= SBCM_SLEEP;
              default: state_q <= SBCM_NORMAL;
            endcase
          end
        end
        SBCM_RESTART: begin
          if (ro_rise) begin
            state_q <= SBCM_NORMAL;
          end
        end
        SBCM_FAILSAFE: begin
          if (i_wake_event) begin
            state_q <= SBCM_RESTART;
          end
        end
        default: state_q <= SBCM_INIT;
      endcase
    end
  end

  // Watchdog long open window and failure count
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      wd_cnt_q   <= 32'(LONG_WINDOW_CYC);
      wd_fails_q <= 2'h0;
      wd_cfg_q   <= 1'h0;
    end else begin
      if (!ro_b_q || i_wd_trigger) begin
        wd_cnt_q <= 32'(LONG_WINDOW_CYC);
      end else if (wd_cnt_q != 32'h0) begin
        wd_cnt_q <= wd_cnt_q - 32'h1;
      end
      if (i_wd_trigger && state_q == SBCM_INIT) begin
        wd_cfg_q <= 1'h1;
      end
      if (wd_expire && wd_fails_q != 2'h3) begin
        wd_fails_q <= wd_fails_q + 2'h1;
      end
    end
  end

  // Fail outputs, sticky across Restart, test bit in Normal
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      fail_q <= 1'h0;
    end else if (reg_ok && wd_expire && wd_fail_out) begin
      fail_q <= 1'h1;
    end else if (reg_ok && ov_event && i_overvoltage_reset_enable) begin
      fail_q <= 1'h1;
    end
  end

  // Fail pin level, low while active or under test
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      fail_b_q <= 1'h1;
    end else begin
      fail_b_q <= !(fail_q || (state_q == SBCM_NORMAL && i_fail_output_test_bit));
    end
  end

  // Flags: POR, overvoltage, undervoltage; POR only clears, the other two only set
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      por_q     <= 1'h1;
      ov_q      <= 1'h0;
      ov_seen_q <= 1'h0;
      uv_q      <= 1'h0;
    end else begin
      ov_seen_q <= ov_now;
      if (i_por_flag_clear) begin
        por_q <= 1'h0;
      end
      if (ov_event) begin
        ov_q <= 1'h1;
      end
      if (!reg_ok && ro_b_q) begin
        uv_q <= 1'h1;
      end
    end
  end

  // Mode field, peripherals and wake interrupt
  always_ff @(posedge i_clock) begin
    if (!i_rst_b) begin
      mode_q   <= `SBCM_MODE_RST_VAL;
      periph_q <= '0;
      int_q    <= 1'h0;
    end else begin
      int_q <= state_q == SBCM_NORMAL && i_wake_event;
      if (state_q == SBCM_RESTART) begin
        mode_q                <= `SBCM_MODE_RST_VAL;
        periph_q.high_side_on        <= 1'h0;
        periph_q.second_regulator_on <= 1'h0;
      end else if (state_q == SBCM_NORMAL && i_mode_write) begin
        mode_q <= i_mode_field;
      end
    end
  end

  assign o_int_pulldown_oe    = sampling;
  assign o_int_pin_low        = 1'h0;
  assign o_reset_output_pin_b = ro_b_q;
  assign o_fail_outputs_b     = fail_b_q;
  assign o_overvoltage_flag   = ov_q;
  assign o_undervoltage_flag  = uv_q;
  assign o_por_flag           = por_q;
  assign o_mode_field         = mode_q;
  assign o_cfg                = cfg_q;
  assign o_periph             = periph_q;
  assign o_wd_configured      = wd_cfg_q;
  assign o_wd_fail            = int_q;
  assign o_state              = state_q;
endmodule : sbcm_ctrl

// >>> src/sbcm_map.svh
/*
 Constants for the power-up and mode-control block: clock rate, reset values,
 timing counts at a 50 MHz system clock.
 Assumes inclusion by bare name; holds definitions only.
*/
`ifndef SBCM_MAP_SVH
`define SBCM_MAP_SVH
`define SBCM_CLK_MHZ          50
`define SBCM_RESET_DELAY_US   10
`define SBCM_RESET_DELAY_CYC  (`SBCM_RESET_DELAY_US * `SBCM_CLK_MHZ)
`define SBCM_LONG_WINDOW_MS   200
`define SBCM_LONG_WINDOW_CYC  (`SBCM_LONG_WINDOW_MS * 1000 * `SBCM_CLK_MHZ)
`define SBCM_CFG_FILT_US      2
`define SBCM_CFG_FILT_CYC     (`SBCM_CFG_FILT_US * `SBCM_CLK_MHZ)
`define SBCM_MODE_RST_VAL     2'h0
`define SBCM_CFG_RST_VAL      1'h0
`endif

// >>> src/sbcm_pkg.sv
/*
 Types for the power-up and mode-control block.
 Assumes nothing beyond a SystemVerilog compiler.
*/
package sbcm_pkg;
  typedef enum logic [2:0] {
    SBCM_INIT     = 3'h0,
    SBCM_NORMAL   = 3'h1,
    SBCM_RESTART  = 3'h2,
    SBCM_FAILSAFE = 3'h3,
    SBCM_STOP     = 3'h4,
    SBCM_SLEEP    = 3'h5
  } sbcm_state_e;
  typedef struct packed {
    logic pullup_config_latch;
    logic count_select;
    logic dev_mode;
  } sbcm_cfg_s;
  typedef struct packed {
    logic second_regulator_on;
    logic third_regulator_on;
    logic can_on;
    logic lin_on;
    logic high_side_on;
  } sbcm_periph_s;
endpackage : sbcm_pkg

// >>> verification/sbcm_chk_assertions.sv
/* Port checker of the mode-control block.
   Assumes bind onto sbcm_ctrl, one clock domain. */
`timescale 1ns/1ps
module sbcm_chk
  import sbcm_pkg::*;
#(
  parameter int LONG_WINDOW_CYC = 200,
  parameter int RESET_DELAY_CYC = 20
) (
  input wire logic         i_clock,
  input wire logic         i_rst_b,
  input wire logic         i_main_reg_ok,
  input wire logic         i_spi_cmd,
  input wire logic         i_wake_event,
  input wire logic         i_overvoltage_reset_enable,
  input wire logic         o_int_pulldown_oe,
  input wire logic         o_reset_output_pin_b,
  input wire logic         o_fail_outputs_b,
  input wire logic         o_overvoltage_flag,
  input wire logic         o_undervoltage_flag,
  input wire sbcm_cfg_s    o_cfg,
  input wire sbcm_periph_s o_periph,
  input wire logic         o_wd_fail,
  input wire sbcm_state_e  o_state
);
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_rst_b);
  AST_INIT_SPI: assert property (o_state == SBCM_INIT && i_spi_cmd && o_reset_output_pin_b
    |=> o_state == SBCM_NORMAL) else $error("command kept init");
  AST_INIT_WAKE: assert property (o_state == SBCM_INIT && i_wake_event
    |=> (!o_wd_fail)[*2]) else $error("wake seen in init");
  AST_NORMAL_WAKE: assert property (o_state == SBCM_NORMAL && i_wake_event
    |-> ##[1:2] o_wd_fail) else $error("wake lost in normal");
  AST_RESTART_RO: assert property ((o_state == SBCM_RESTART)[*2]
    |-> !o_reset_output_pin_b) else $error("reset high in restart");
  AST_OV_KEEP: assert property ($rose(o_overvoltage_flag) && !i_overvoltage_reset_enable
    |-> o_state == $past(o_state)) else $error("mode moved on overvoltage");
  AST_OV_ACT: assert property ($rose(o_overvoltage_flag) && i_overvoltage_reset_enable
    |-> ##[0:3] (!o_fail_outputs_b && o_state == (o_cfg.pullup_config_latch ?
    SBCM_RESTART : SBCM_FAILSAFE))) else $error("overvoltage reaction wrong");
  AST_CFG_HOLD: assert property (o_reset_output_pin_b && $past(o_reset_output_pin_b)
    |-> $stable(o_cfg)) else $error("config changed");
  AST_POWER: assert property ((o_state == SBCM_INIT && !i_main_reg_ok)[*4]
    |-> !o_reset_output_pin_b && !o_undervoltage_flag) else $error("power-up output wrong");
  AST_PULLDOWN: assert property (o_int_pulldown_oe
    |-> !o_reset_output_pin_b) else $error("pull-down outside reset");
  AST_NORMAL_ENTRY: assert property (o_state == SBCM_NORMAL && $past(o_state) == SBCM_INIT
    |-> o_periph == '0) else $error("periph on at entry");
endmodule : sbcm_chk
bind sbcm_ctrl sbcm_chk #(.LONG_WINDOW_CYC(LONG_WINDOW_CYC), .RESET_DELAY_CYC(RESET_DELAY_CYC))
  u_chk (.i_clock, .i_rst_b, .i_main_reg_ok, .i_spi_cmd, .i_wake_event,
  .i_overvoltage_reset_enable, .o_int_pulldown_oe, .o_reset_output_pin_b, .o_fail_outputs_b,
  .o_overvoltage_flag, .o_undervoltage_flag, .o_cfg, .o_periph, .o_wd_fail, .o_state);

// >>> verification/sbcm_host.sv
/* Host model: interrupt pin pull-up, command frames, triggers.
   Assumes tasks are called at a falling clock edge. */
`timescale 1ns/1ps
module sbcm_host (
  input  wire logic i_clock,
  input  wire logic i_pullup,
  input  wire logic i_pulldown_oe,
  output logic      o_int_level,
  output logic      o_spi_cmd,
  output logic      o_wd_trigger
);
  logic sclk = 1'b0;
  logic flt = 1'b0;
  always @(posedge i_clock) flt <= ~flt;
  // Floating pin toggles
  assign o_int_level = i_pullup ? 1'b1 : (i_pulldown_oe ? 1'b0 : flt);
  initial begin
    o_spi_cmd = 1'b0;
    o_wd_trigger = 1'b0;
  end
  task automatic frame(input logic trig);
    repeat (32) #80 sclk = ~sclk;
    @(negedge i_clock);
    o_spi_cmd = 1'b1;
    o_wd_trigger = trig;
    @(negedge i_clock);
    o_spi_cmd = 1'b0;
    o_wd_trigger = 1'b0;
  endtask : frame
endmodule : sbcm_host

// >>> verification/sbcm_ctrl_tb.sv
/* Bench of the mode-control block against a host model.
   Assumes the checker binds itself. */
`timescale 1ns/1ps
module sbcm_ctrl_tb
  import sbcm_pkg::*;
;
  typedef struct packed {logic [2:0] k; logic [7:0] v;} sbcm_note_s;
  logic i_clock = 1'b0, i_rst_b = 1'b0, i_main_reg_ok = 1'b0, i_main_reg_ov = 1'b0;
  logic i_fail3_test_pin = 1'b1, i_wake_event = 1'b0, i_count_select = 1'b0;
  logic i_overvoltage_reset_enable = 1'b0, i_por_flag_clear = 1'b0;
  logic i_fail_output_test_bit = 1'b0, pu = 1'b0, wk = 1'b0, fsafe;
  logic i_mode_write = 1'b0;
  logic [1:0] i_mode_field = 2'h0, md;
  logic [7:0] got;
  wire logic i_int_pin, i_spi_cmd, i_wd_trigger, o_int_pulldown_oe, o_reset_output_pin_b;
  wire logic o_fail_outputs_b, o_overvoltage_flag, o_undervoltage_flag, o_wd_fail;
  wire logic o_por_flag, o_wd_configured;
  wire logic [1:0] o_mode_field;
  sbcm_cfg_s o_cfg;
  sbcm_periph_s o_periph;
  sbcm_state_e o_state;
  sbcm_note_s q[$], nt;
  int c, n_errors = 0, n_tests = 0, cyc = 0;
  event obs;
  sbcm_ctrl #(.LONG_WINDOW_CYC(200), .RESET_DELAY_CYC(150)) uut (.i_clock, .i_rst_b,
    .i_main_reg_ok, .i_main_reg_ov, .i_int_pin, .i_fail3_test_pin, .i_spi_cmd, .i_wd_trigger,
    .i_wake_event, .i_count_select, .i_overvoltage_reset_enable, .i_por_flag_clear,
    .i_mode_write, .i_mode_field, .i_fail_output_test_bit, .o_int_pulldown_oe,
    .o_int_pin_low(), .o_reset_output_pin_b, .o_fail_outputs_b, .o_overvoltage_flag,
    .o_undervoltage_flag, .o_por_flag, .o_mode_field, .o_cfg, .o_periph,
    .o_wd_configured, .o_wd_fail, .o_state);
  sbcm_host host (.i_clock, .i_pullup(pu), .i_pulldown_oe(o_int_pulldown_oe),
    .o_int_level(i_int_pin), .o_spi_cmd(i_spi_cmd), .o_wd_trigger(i_wd_trigger));
  always #10 i_clock = ~i_clock;
  always @(posedge i_clock) if (o_wd_fail === 1'b1) wk <= 1'b1;
  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      n_errors++;
      report_and_stop();
    end
  end
  task automatic report_and_stop();
    $display("tests=%0d errors=%0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : report_and_stop
  task automatic chk(input logic [7:0] g, input logic [7:0] e);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  always begin
    @(obs);
    nt = q.pop_front();
    case (nt.k)
      3'h0: got = {5'h0, o_state};
      3'h1: got = {7'h0, o_reset_output_pin_b};
      3'h2: got = {7'h0, o_fail_outputs_b};
      3'h3: got = {7'h0, o_overvoltage_flag};
      3'h4: got = {5'h0, o_wd_configured, o_por_flag, o_undervoltage_flag};
      3'h5: got = {5'h0, o_cfg};
      3'h6: got = {1'b0, o_mode_field, o_periph};
      default: got = {7'h0, wk};
    endcase
    chk(got, nt.v);
  end
  task automatic note(input logic [2:0] k, input logic [7:0] v);
    q.push_back('{k, v});
    -> obs;
    #1;
  endtask : note
  task automatic wake(input sbcm_state_e s);
    wk = 1'b0;
    i_wake_event = 1'b1;
    @(negedge i_clock);
    i_wake_event = 1'b0;
    repeat (3) @(negedge i_clock);
    note(3'h7, {7'h0, s == SBCM_NORMAL});
    note(3'h0, {5'h0, s});
  endtask : wake
  task automatic ov_step(input logic en);
    i_main_reg_ov = 1'b0;
    i_overvoltage_reset_enable = en;
    repeat (4) @(negedge i_clock);
    i_main_reg_ov = 1'b1;
    repeat (8) @(negedge i_clock);
  endtask : ov_step
  task automatic power_up(input logic tp);
    i_rst_b = 1'b0;
    i_main_reg_ok = 1'b0;
    i_main_reg_ov = 1'b0;
    i_overvoltage_reset_enable = 1'b0;
    i_fail3_test_pin = tp;
    repeat (8) @(negedge i_clock);
    i_rst_b = 1'b1;
    repeat (30) @(negedge i_clock);
    note(3'h1, 8'h0);
    note(3'h4, 8'h2);
    note(3'h0, {5'h0, SBCM_INIT});
    i_main_reg_ok = 1'b1;
    while (o_reset_output_pin_b !== 1'b1) @(negedge i_clock);
    note(3'h5, {5'h0, pu, i_count_select, ~tp});
  endtask : power_up
  initial begin
    void'($urandom(32'hADAE));
    for (c = 0; c < 8; c++) begin
      pu = c[0];
      i_count_select = c[1];
      power_up(c < 4 ? 1'b1 : 1'($urandom()));
      wake(SBCM_INIT);
      host.frame(c > 3);
      @(negedge i_clock);
      note(3'h0, {5'h0, SBCM_NORMAL});
      note(3'h4, {5'h0, c > 3, 2'h2});
      note(3'h6, 8'h0);
      note(3'h2, 8'h1);
      wake(SBCM_NORMAL);
      if (c < 4) begin
        for (int n = 1; n < 3; n++) begin
          fsafe = !pu && (i_count_select || n == 2);
          while (o_reset_output_pin_b !== 1'b0) @(negedge i_clock);
          repeat (2) @(negedge i_clock);
          note(3'h1, 8'h0);
          note(3'h2, {7'h0, !(i_count_select || n == 2)});
          note(3'h0, {5'h0, fsafe ? SBCM_FAILSAFE : SBCM_RESTART});
          if (fsafe) break;
          while (o_reset_output_pin_b !== 1'b1) @(negedge i_clock);
          @(negedge i_clock);
          note(3'h0, {5'h0, SBCM_NORMAL});
          note(3'h6, 8'h0);
        end
      end else begin
        i_por_flag_clear = 1'b1;
        i_fail_output_test_bit = 1'b1;
        repeat (2) @(negedge i_clock);
        note(3'h2, 8'h0);
        note(3'h4, 8'h4);
        i_por_flag_clear = 1'b0;
        i_fail_output_test_bit = 1'b0;
        repeat (2) @(negedge i_clock);
        note(3'h2, 8'h1);
        ov_step(1'b0);
        note(3'h3, 8'h1);
        note(3'h2, 8'h1);
        note(3'h0, {5'h0, SBCM_NORMAL});
        md = 2'($urandom_range(2, 1));
        i_mode_write = 1'b1;
        i_mode_field = md;
        @(negedge i_clock);
        i_mode_write = 1'b0;
        @(negedge i_clock);
        note(3'h6, {1'b0, md, 5'h0});
        note(3'h0, {5'h0, md == 2'h1 ? SBCM_STOP : SBCM_SLEEP});
        ov_step(1'b1);
        note(3'h2, 8'h0);
        note(3'h0, {5'h0, pu ? SBCM_RESTART : SBCM_FAILSAFE});
        i_wake_event = !pu;
        @(negedge i_clock);
        i_wake_event = 1'b0;
        while (o_reset_output_pin_b !== 1'b1) @(negedge i_clock);
        @(negedge i_clock);
        note(3'h0, {5'h0, SBCM_NORMAL});
        note(3'h6, 8'h0);
        note(3'h2, 8'h0);
      end
    end
    #1;
    report_and_stop();
  end
endmodule : sbcm_ctrl_tb
